// ===== inc/ssf_pkg.sv
package ssf_pkg;

	// Register port geometry.
	localparam int unsigned SSF_ADDR_W = 8;
	localparam int unsigned SSF_DATA_W = 8;
	localparam int unsigned SSF_CHAN_N = 6;
	localparam int unsigned SSF_CODE_W = 8;

	// Register offsets on the management bus.
	localparam logic [7:0] SSF_VENDOR_FAULT_FLAGS_OFS = 8'h24;
	localparam logic [7:0] SSF_MONITOR_PIN_STATE_OFS = 8'h30;
	localparam logic [7:0] SSF_SELFTEST_ECC_INFO_OFS = 8'h31;
	localparam logic [7:0] SSF_CHANNEL_OFF_FLAGS_OFS = 8'h32;

	// Field positions in vendor_fault_flags.
	localparam int unsigned SSF_VF_REGULATOR_BIT = 6;
	localparam int unsigned SSF_VF_OSCILLATOR_BIT = 4;
	localparam int unsigned SSF_VF_ADDR_SHORT_BIT = 3;
	localparam int unsigned SSF_VF_ADDR_OPEN_BIT = 2;

	// Field positions in monitor_pin_state.
	localparam int unsigned SSF_MP_SAFE_STATE_BIT = 7;
	localparam int unsigned SSF_MP_SELFTEST_DONE_BIT = 6;
	localparam int unsigned SSF_MP_SUPPLY_BIT = 5;
	localparam int unsigned SSF_MP_IRQ_BIT = 4;
	localparam int unsigned SSF_MP_SLEEP_BIT = 3;
	localparam int unsigned SSF_MP_ACTIVATION_BIT = 2;
	localparam int unsigned SSF_MP_TAG_BIT = 1;

	// Field positions in selftest_ecc_info.
	localparam int unsigned SSF_TI_SINGLE_BIT = 5;
	localparam int unsigned SSF_TI_DOUBLE_BIT = 4;
	localparam int unsigned SSF_TI_VOLATILE_BIT = 3;
	localparam int unsigned SSF_TI_NONVOLATILE_BIT = 2;
	localparam int unsigned SSF_TI_LOGIC_BIT = 1;
	localparam int unsigned SSF_TI_ANALOG_BIT = 0;

	// Implemented-bit masks; every other position is reserved.
	localparam logic [7:0] SSF_VENDOR_MASK = 8'h5c;
	localparam logic [7:0] SSF_OFF_MASK = 8'h3f;

	// Reset values; the hardware leaves them undefined, zero is used here.
	localparam logic [7:0] SSF_REG_RESET = 8'h00;
	localparam logic SSF_BIT_RESET = 1'b0;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ssf_req_t;

	typedef struct packed {
		logic regulator_fault;
		logic oscillator_fault;
		logic addr_pin_short_fault;
		logic addr_pin_open_fault;
	} ssf_fault_t;

	typedef struct packed {
		logic supply_pin_level;
		logic irq_pin_level;
		logic sleep_pin_level;
		logic activation_pin_level;
		logic tag_pin_level;
	} ssf_pins_t;

	typedef struct packed {
		logic selftest_volatile_fail;
		logic selftest_nonvolatile_fail;
		logic selftest_logic_fail;
		logic selftest_analog_fail;
	} ssf_bist_t;

	typedef enum logic [1:0] {
		SSF_BIST_IDLE = 2'b00,
		SSF_BIST_RUN = 2'b01,
		SSF_BIST_DONE = 2'b10
	} ssf_bist_state_t;

endpackage

// ===== src/ssf_chan_off.sv
`timescale 1ns/100ps
module ssf_chan_off
	import ssf_pkg::*;
#(
	parameter int unsigned CHAN_N = 6,
	parameter int unsigned CODE_W = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic [CHAN_N*CODE_W-1:0] level_in,
	input wire logic [CHAN_N*CODE_W-1:0] off_thr_in,
	output logic [CHAN_N-1:0] below_out
);
	genvar c;
	// Each channel compares its measured code against its own off threshold.
	generate
		for (c = 0; c < CHAN_N; c++) begin : g_chan
			logic below_reg;
			always_ff @(posedge sys_clk_in or posedge rst_in) begin
				if (rst_in) begin
					below_reg <= SSF_BIT_RESET;
				end else if (clk_en_in) begin
					below_reg <= level_in[c*CODE_W +: CODE_W] < off_thr_in[c*CODE_W +: CODE_W];
				end
			end
			assign below_out[c] = below_reg;
		end
	endgenerate

endmodule // ssf_chan_off

// ===== src/ssf_status_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Regulator fault sets vendor flag bit 6; a host one-write or a reset clears it.
// - Oscillator fault sets vendor flag bit 4; writing one clears it.
// - Address pin short sets bit 3, open sets bit 2; each cleared by one.
// - Monitor bit 7 reads one while in the safe state, else zero.
// - Monitor bit 6 reads one once self-test has completed, else zero.
// - Monitor bit 5 follows the supply pin level.
// - Monitor bit 4 follows the interrupt request pin level.
// - Monitor bit 3 follows the sleep input level.
// - Monitor bit 2 follows the activation input level.
// - Monitor bit 1 follows the rail tagging sync pin level.
// - Info bit 5 reads one if configuration load corrected a single error.
// - Info bit 4 reads one if configuration load found a double error.
// - Info bit 3 is the volatile memory self-test result, one is fail.
// - Info bit 2 is the non-volatile memory self-test result, one is fail.
// - Info bit 1 is the logic self-test result, one is fail.
// - Info bit 0 is the analog self-test result, one is fail.
// - Off flags bits 5 to 0 read one when a channel is below off.
module ssf_status_regs
	import ssf_pkg::*;
#(
	parameter int unsigned CHAN_N = SSF_CHAN_N,
	parameter int unsigned CODE_W = SSF_CODE_W
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire ssf_req_t reg_req_in,
	output logic [SSF_DATA_W-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire ssf_fault_t fault_in,
	input wire logic safe_state_in,
	input wire ssf_pins_t pins_in,
	input wire logic selftest_start_in,
	input wire logic selftest_done_in,
	input wire ssf_bist_t selftest_result_in,
	input wire logic config_load_done_in,
	input wire logic config_single_corrected_in,
	input wire logic config_double_detected_in,
	input wire logic [CHAN_N*CODE_W-1:0] chan_level_in,
	input wire logic [CHAN_N*CODE_W-1:0] chan_off_thr_in,
	output logic [CHAN_N-1:0] channel_below_off_out,
	output logic selftest_done_state_out
);

	// Decoded register strobes.
	logic hit_vendor;
	logic hit_monitor;
	logic hit_info;
	logic hit_off;
	logic vendor_wr;

	// Flag sources and register images.
	logic [SSF_DATA_W-1:0] vendor_set;
	logic [SSF_DATA_W-1:0] vendor_clr;
	logic [SSF_DATA_W-1:0] vendor_fault_flags;
	logic [SSF_DATA_W-1:0] monitor_pin_state;
	logic [SSF_DATA_W-1:0] selftest_ecc_info;
	logic [SSF_DATA_W-1:0] channel_off_flags;
	logic [CHAN_N-1:0] chan_below;

	// Registered status state.
	logic safe_state_flag_reg;
	ssf_pins_t pins_reg;
	ssf_bist_state_t bist_state_reg;
	ssf_bist_state_t bist_state_next;
	ssf_bist_t bist_result_reg;
	logic config_single_corrected_reg;
	logic config_double_detected_reg;

	// Read path registers.
	logic [SSF_DATA_W-1:0] rd_data_reg;
	logic [SSF_DATA_W-1:0] rd_data_next;
	logic rd_valid_reg;

	// Address decode is exact; anything else is unmapped and reads zero.
	assign hit_vendor = reg_req_in.addr == SSF_VENDOR_FAULT_FLAGS_OFS;
	assign hit_monitor = reg_req_in.addr == SSF_MONITOR_PIN_STATE_OFS;
	assign hit_info = reg_req_in.addr == SSF_SELFTEST_ECC_INFO_OFS;
	assign hit_off = reg_req_in.addr == SSF_CHANNEL_OFF_FLAGS_OFS;

	// Only the vendor register takes writes; the other three are read-only.
	assign vendor_wr = reg_req_in.wr & hit_vendor;

	// Fault detectors feed the sticky flags at their own bit positions.
	always_comb begin
		vendor_set = SSF_REG_RESET;
		vendor_set[SSF_VF_REGULATOR_BIT] = fault_in.regulator_fault;
		vendor_set[SSF_VF_OSCILLATOR_BIT] = fault_in.oscillator_fault;
		vendor_set[SSF_VF_ADDR_SHORT_BIT] = fault_in.addr_pin_short_fault;
		vendor_set[SSF_VF_ADDR_OPEN_BIT] = fault_in.addr_pin_open_fault;
	end

	// A one written to a flag clears it; reserved lanes are masked off.
	always_comb begin
		vendor_clr = SSF_REG_RESET;
		if (vendor_wr) begin
			vendor_clr = reg_req_in.wdata & SSF_VENDOR_MASK;
		end
	end

	// Sticky fault flags with set priority over the host clear.
	ssf_w1c_flags #(
		.WIDTH(SSF_DATA_W),
		.IMPL_MASK(SSF_VENDOR_MASK)
	) u_vendor_flags (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.set_in(vendor_set),
		.clr_in(vendor_clr),
		.flags_out(vendor_fault_flags)
	);

	// Per-channel below-off detection.
	ssf_chan_off #(
		.CHAN_N(CHAN_N),
		.CODE_W(CODE_W)
	) u_chan_off (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.level_in(chan_level_in),
		.off_thr_in(chan_off_thr_in),
		.below_out(chan_below)
	);

	// The safe state is a live condition, not sticky, so it is resampled
	// every cycle and falls as soon as the device leaves that state.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			safe_state_flag_reg <= SSF_BIT_RESET;
		end else if (clk_en_in) begin
			safe_state_flag_reg <= safe_state_in;
		end
	end

	// Pin levels are already synchronous, so one register stage suffices.
	// The status therefore trails the pin by exactly one clock.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pins_reg <= '0;
		end else if (clk_en_in) begin
			pins_reg <= pins_in;
		end
	end

	// Self-test tracking: a start drops the done state, completion raises it.
	// A done pulse is honoured from any state so a missed start is harmless.
	always_comb begin
		bist_state_next = bist_state_reg;
		unique case (bist_state_reg)
			SSF_BIST_IDLE: begin
				if (selftest_done_in) begin
					bist_state_next = SSF_BIST_DONE;
				end else if (selftest_start_in) begin
					bist_state_next = SSF_BIST_RUN;
				end
			end
			SSF_BIST_RUN: begin
				if (selftest_done_in) begin
					bist_state_next = SSF_BIST_DONE;
				end
			end
			SSF_BIST_DONE: begin
				if (selftest_done_in) begin
					bist_state_next = SSF_BIST_DONE;
				end else if (selftest_start_in) begin
					bist_state_next = SSF_BIST_RUN;
				end
			end
			default: begin
				bist_state_next = SSF_BIST_IDLE;
			end
		endcase
	end

	// Self-test state register.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bist_state_reg <= SSF_BIST_IDLE;
		end else if (clk_en_in) begin
			bist_state_reg <= bist_state_next;
		end
	end

	// Results are captured on completion and held until the next one,
	// so software reads a stable verdict between test runs.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bist_result_reg <= '0;
		end else if (clk_en_in && selftest_done_in) begin
			bist_result_reg <= selftest_result_in;
		end
	end

	// Correction outcome of the configuration load, held until the next load.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			config_single_corrected_reg <= SSF_BIT_RESET;
			config_double_detected_reg <= SSF_BIT_RESET;
		end else if (clk_en_in && config_load_done_in) begin
			config_single_corrected_reg <= config_single_corrected_in;
			config_double_detected_reg <= config_double_detected_in;
		end
	end

	// Monitor register image; bit 0 is reserved and stays zero.
	always_comb begin
		monitor_pin_state = SSF_REG_RESET;
		monitor_pin_state[SSF_MP_SAFE_STATE_BIT] = safe_state_flag_reg;
		monitor_pin_state[SSF_MP_SELFTEST_DONE_BIT] = bist_state_reg == SSF_BIST_DONE;
		monitor_pin_state[SSF_MP_SUPPLY_BIT] = pins_reg.supply_pin_level;
		monitor_pin_state[SSF_MP_IRQ_BIT] = pins_reg.irq_pin_level;
		monitor_pin_state[SSF_MP_SLEEP_BIT] = pins_reg.sleep_pin_level;
		monitor_pin_state[SSF_MP_ACTIVATION_BIT] = pins_reg.activation_pin_level;
		monitor_pin_state[SSF_MP_TAG_BIT] = pins_reg.tag_pin_level;
	end

	// Test information image; bits 7 and 6 are reserved.
	always_comb begin
		selftest_ecc_info = SSF_REG_RESET;
		selftest_ecc_info[SSF_TI_SINGLE_BIT] = config_single_corrected_reg;
		selftest_ecc_info[SSF_TI_DOUBLE_BIT] = config_double_detected_reg;
		selftest_ecc_info[SSF_TI_VOLATILE_BIT] =
			bist_result_reg.selftest_volatile_fail;
		selftest_ecc_info[SSF_TI_NONVOLATILE_BIT] =
			bist_result_reg.selftest_nonvolatile_fail;
		selftest_ecc_info[SSF_TI_LOGIC_BIT] = bist_result_reg.selftest_logic_fail;
		selftest_ecc_info[SSF_TI_ANALOG_BIT] = bist_result_reg.selftest_analog_fail;
	end

	// Channel flags sit in the low bits; the upper two lanes read zero.
	always_comb begin
		channel_off_flags = SSF_REG_RESET;
		channel_off_flags[CHAN_N-1:0] = chan_below;
		channel_off_flags = channel_off_flags & SSF_OFF_MASK;
	end

	// Read multiplexer; an unmapped address answers with zero data.
	always_comb begin
		rd_data_next = SSF_REG_RESET;
		if (hit_vendor) begin
			rd_data_next = vendor_fault_flags;
		end else if (hit_monitor) begin
			rd_data_next = monitor_pin_state;
		end else if (hit_info) begin
			rd_data_next = selftest_ecc_info;
		end else if (hit_off) begin
			rd_data_next = channel_off_flags;
		end
	end

	// Read data is registered and held until the next read, so the serial
	// engine may shift it out over many bit times without it moving.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_reg <= SSF_REG_RESET;
		end else if (clk_en_in && reg_req_in.rd) begin
			rd_data_reg <= rd_data_next;
		end
	end

	// Read completion pulse, one clock after the request was taken.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_valid_reg <= SSF_BIT_RESET;
		end else if (clk_en_in) begin
			rd_valid_reg <= reg_req_in.rd;
		end
	end

	// Output drive.
	assign rd_data_out = rd_data_reg;
	assign rd_valid_out = rd_valid_reg;
	assign channel_below_off_out = chan_below;
	assign selftest_done_state_out = bist_state_reg == SSF_BIST_DONE;

endmodule // ssf_status_regs

// ===== src/ssf_w1c_flags.sv
`timescale 1ns/100ps
module ssf_w1c_flags
	import ssf_pkg::*;
#(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	output logic [WIDTH-1:0] flags_out
);
	genvar i;
	// One sticky flag per implemented bit; reserved bits are constant zero.
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			if (IMPL_MASK[i]) begin : g_impl
				logic flag_reg;
				// Set wins over clear so an event in the clearing cycle is kept.
				always_ff @(posedge sys_clk_in or posedge rst_in) begin
					if (rst_in) begin
						flag_reg <= SSF_BIT_RESET;
					end else if (clk_en_in) begin
						flag_reg <= set_in[i] | (flag_reg & ~clr_in[i]);
					end
				end
				assign flags_out[i] = flag_reg;
			end else begin : g_rsvd
				assign flags_out[i] = 1'b0;
			end
		end
	endgenerate

endmodule // ssf_w1c_flags

// ===== tb/ssf_host_model.sv
`timescale 1ns/100ps
// Host behind the management bus engine; it changes requests only just after a rising edge.
module ssf_host_model
	import ssf_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic [SSF_DATA_W-1:0] rd_data_in,
	input wire logic rd_valid_in,
	output ssf_req_t req_out
);
	initial begin
		req_out = '0;
	end
	// Write pulse of one cycle; the bank gives no answer to a write.
	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk_in);
		req_out <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_in);
		req_out.wr <= 1'b0;
	endtask
	// Read pulse, then a bounded wait so a dead bank cannot hang the run.
	task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output bit ok);
		ok = 1'b0;
		data = 8'h00;
		@(posedge sys_clk_in);
		req_out <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_in);
		req_out.rd <= 1'b0;
		// The answer is taken at the edge that samples the valid pulse high,
		// so the caller resumes on a rising edge and drives inputs from there.
		for (int i = 0; i < 3 && !ok; i++) begin
			@(posedge sys_clk_in);
			if (rd_valid_in === 1'b1) begin
				data = rd_data_in;
				ok = 1'b1;
			end
		end
	endtask
endmodule // ssf_host_model

// ===== tb/ssf_status_regs_properties.sv
`timescale 1ns/100ps
// Port-level checks of the status bank; it watches inputs and outputs, never drives anything.
module ssf_status_regs_properties
	import ssf_pkg::*;
#(
	parameter int unsigned CHAN_N = SSF_CHAN_N,
	parameter int unsigned CODE_W = SSF_CODE_W
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire ssf_req_t reg_req_in,
	input wire logic [SSF_DATA_W-1:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire ssf_fault_t fault_in,
	input wire logic safe_state_in,
	input wire ssf_pins_t pins_in,
	input wire logic selftest_start_in,
	input wire logic selftest_done_in,
	input wire ssf_bist_t selftest_result_in,
	input wire logic config_load_done_in,
	input wire logic config_single_corrected_in,
	input wire logic config_double_detected_in,
	input wire logic [CHAN_N*CODE_W-1:0] chan_level_in,
	input wire logic [CHAN_N*CODE_W-1:0] chan_off_thr_in,
	input wire logic [CHAN_N-1:0] channel_below_off_out,
	input wire logic selftest_done_state_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	logic [CHAN_N-1:0] exp_below;
	// Reference comparison per channel, kept apart from the design's detector.
	always_comb begin
		for (int c = 0; c < CHAN_N; c++) begin
			exp_below[c] = chan_level_in[c*CODE_W +: CODE_W] < chan_off_thr_in[c*CODE_W +: CODE_W];
		end
	end
	sequence s_read_taken;
		clk_en_in && reg_req_in.rd;
	endsequence
	sequence s_read_at(logic [7:0] a);
		clk_en_in && reg_req_in.rd && reg_req_in.addr == a;
	endsequence
	chk_read_valid_pulse: assert property (s_read_taken |=> rd_valid_out)
		else $error("read not answered one cycle later");
	chk_no_stray_valid: assert property (clk_en_in && !reg_req_in.rd |=> !rd_valid_out)
		else $error("answer pulse without a read");
	chk_data_holds: assert property (!(clk_en_in && reg_req_in.rd) |=> $stable(rd_data_out))
		else $error("read data moved without a read");
	chk_monitor_image: assert property (s_read_at(8'h30) ##0 !$past(rst_in) |=> rd_data_out ==
		{$past(safe_state_in, 2), $past(selftest_done_state_out), $past(pins_in, 2), 1'b0})
		else $error("monitor image differs from pins");
	chk_off_image: assert property (s_read_at(8'h32) |=> rd_data_out == {2'b00, $past(channel_below_off_out)})
		else $error("off flags read differs from channel flags");
	chk_chan_compare: assert property (clk_en_in |=> channel_below_off_out == $past(exp_below))
		else $error("channel below-off flag wrong");
	chk_vendor_reserved: assert property (s_read_at(8'h24) |=> (rd_data_out & ~SSF_VENDOR_MASK) == 8'h00)
		else $error("reserved fault bit read as one");
	chk_info_reserved: assert property (s_read_at(8'h31) |=> rd_data_out[7:6] == 2'b00)
		else $error("reserved info bit read as one");
	chk_done_sets: assert property (clk_en_in && selftest_done_in |=> selftest_done_state_out)
		else $error("self-test done not shown");
	chk_start_clears: assert property (clk_en_in && selftest_start_in && !selftest_done_in
		|=> !selftest_done_state_out)
		else $error("self-test done not cleared by start");
	chk_done_steady: assert property (!selftest_start_in && !selftest_done_in
		|=> $stable(selftest_done_state_out))
		else $error("self-test done state moved by itself");
endmodule // ssf_status_regs_properties

// ===== tb/ssf_status_regs_tb.sv
`timescale 1ns/100ps
module ssf_status_regs_tb
	import ssf_pkg::*;
;
	localparam int unsigned CHAN_N = SSF_CHAN_N;
	localparam int unsigned CODE_W = SSF_CODE_W;
	logic sys_clk_in, rst_in, clk_en_in, rd_valid_out, safe_state_in, selftest_start_in;
	logic selftest_done_in, config_load_done_in, config_single_corrected_in;
	logic config_double_detected_in, selftest_done_state_out;
	logic [7:0] rd_data_out;
	ssf_req_t reg_req_in;
	ssf_fault_t fault_in;
	ssf_pins_t pins_in;
	ssf_bist_t selftest_result_in;
	logic [CHAN_N*CODE_W-1:0] chan_level_in, chan_off_thr_in;
	logic [CHAN_N-1:0] channel_below_off_out;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] vbit [4] = '{8'h40, 8'h10, 8'h08, 8'h04};
	logic [7:0] exp_off;
	ssf_status_regs ssf_status_regs_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.clk_en_in(clk_en_in), .reg_req_in(reg_req_in), .rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out), .fault_in(fault_in), .safe_state_in(safe_state_in),
		.pins_in(pins_in), .selftest_start_in(selftest_start_in),
		.selftest_done_in(selftest_done_in), .selftest_result_in(selftest_result_in),
		.config_load_done_in(config_load_done_in),
		.config_single_corrected_in(config_single_corrected_in),
		.config_double_detected_in(config_double_detected_in), .chan_level_in(chan_level_in),
		.chan_off_thr_in(chan_off_thr_in), .channel_below_off_out(channel_below_off_out),
		.selftest_done_state_out(selftest_done_state_out));
	ssf_host_model ssf_host_model_i (.sys_clk_in(sys_clk_in), .rd_data_in(rd_data_out),
		.rd_valid_in(rd_valid_out), .req_out(reg_req_in));
	// Free-running 200 MHz clock.
	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	// Cycle ceiling well above the roughly 160 cycles the sequence needs.
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			$display("unexpected at %0t: run did not finish", $time);
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Reads a byte and compares it; a missing answer counts as a mismatch.
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] got;
		bit ok;
		ssf_host_model_i.rd_reg(addr, got, ok);
		total_checks++;
		if (!ok || got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: addr %h read %h, expected %h", $time, addr, got, exp);
		end
	endtask
	// Sets the channel inputs and works out the expected flags independently.
	task automatic set_chan(input logic [7:0] thr_ofs, input bit fixed);
		@(posedge sys_clk_in);
		exp_off = 8'h00;
		for (int c = 0; c < CHAN_N; c++) begin
			chan_level_in[c*CODE_W +: CODE_W] <= 8'h10 * (c + 1);
			chan_off_thr_in[c*CODE_W +: CODE_W] <= fixed ? thr_ofs : 8'h10 * (c + 1) + thr_ofs;
			exp_off[c] = fixed ? (8'h10 * (c + 1) < thr_ofs) : (thr_ofs != 0);
		end
	endtask
	initial begin
		{rst_in, clk_en_in} = 2'b11;
		{fault_in, safe_state_in, pins_in, selftest_start_in, selftest_done_in} = '0;
		{selftest_result_in, config_load_done_in} = '0;
		{config_single_corrected_in, config_double_detected_in} = 2'b00;
		{chan_level_in, chan_off_thr_in} = '0;
		repeat (5) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd_chk(SSF_VENDOR_FAULT_FLAGS_OFS, 8'h00);
		// Each fault is sticky, ignores writes of other bits, and clears on its own one.
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk_in);
			fault_in <= 4'b1000 >> i;
			@(posedge sys_clk_in);
			fault_in <= '0;
			rd_chk(SSF_VENDOR_FAULT_FLAGS_OFS, vbit[i]);
			ssf_host_model_i.wr_reg(SSF_VENDOR_FAULT_FLAGS_OFS, ~vbit[i]);
			rd_chk(SSF_VENDOR_FAULT_FLAGS_OFS, vbit[i]);
			ssf_host_model_i.wr_reg(SSF_VENDOR_FAULT_FLAGS_OFS, vbit[i]);
			rd_chk(SSF_VENDOR_FAULT_FLAGS_OFS, 8'h00);
		end
		// A clear that meets a live fault loses; reserved bits stay zero.
		@(posedge sys_clk_in);
		fault_in <= 4'b1111;
		ssf_host_model_i.wr_reg(SSF_VENDOR_FAULT_FLAGS_OFS, 8'hff);
		fault_in <= '0;
		rd_chk(SSF_VENDOR_FAULT_FLAGS_OFS, 8'h5c);
		ssf_host_model_i.wr_reg(SSF_VENDOR_FAULT_FLAGS_OFS, 8'hff);
		rd_chk(SSF_VENDOR_FAULT_FLAGS_OFS, 8'h00);
		// Walking one across the live pin levels.
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk_in);
			pins_in <= 5'b00001 << i;
			rd_chk(SSF_MONITOR_PIN_STATE_OFS, 8'h02 << i);
		end
		@(posedge sys_clk_in);
		pins_in <= '0;
		safe_state_in <= 1'b1;
		rd_chk(SSF_MONITOR_PIN_STATE_OFS, 8'h80);
		ssf_host_model_i.wr_reg(SSF_MONITOR_PIN_STATE_OFS, 8'h00);
		rd_chk(SSF_MONITOR_PIN_STATE_OFS, 8'h80);
		safe_state_in <= 1'b0;
		// Self-test completion, restart, and a second result set.
		@(posedge sys_clk_in);
		selftest_result_in <= 4'b1010;
		selftest_done_in <= 1'b1;
		@(posedge sys_clk_in);
		selftest_done_in <= 1'b0;
		rd_chk(SSF_SELFTEST_ECC_INFO_OFS, 8'h0a);
		rd_chk(SSF_MONITOR_PIN_STATE_OFS, 8'h40);
		selftest_start_in <= 1'b1;
		@(posedge sys_clk_in);
		selftest_start_in <= 1'b0;
		selftest_result_in <= 4'b0101;
		rd_chk(SSF_MONITOR_PIN_STATE_OFS, 8'h00);
		rd_chk(SSF_SELFTEST_ECC_INFO_OFS, 8'h0a);
		selftest_done_in <= 1'b1;
		@(posedge sys_clk_in);
		selftest_done_in <= 1'b0;
		rd_chk(SSF_SELFTEST_ECC_INFO_OFS, 8'h05);
		// Configuration load results, each kind once.
		{config_load_done_in, config_single_corrected_in} <= 2'b11;
		@(posedge sys_clk_in);
		{config_load_done_in, config_single_corrected_in} <= 2'b00;
		rd_chk(SSF_SELFTEST_ECC_INFO_OFS, 8'h25);
		{config_load_done_in, config_double_detected_in} <= 2'b11;
		@(posedge sys_clk_in);
		{config_load_done_in, config_double_detected_in} <= 2'b00;
		rd_chk(SSF_SELFTEST_ECC_INFO_OFS, 8'h15);
		// Channels against a shared threshold, one step above, and exactly equal.
		set_chan(8'h40, 1'b1);
		rd_chk(SSF_CHANNEL_OFF_FLAGS_OFS, exp_off);
		set_chan(8'h01, 1'b0);
		rd_chk(SSF_CHANNEL_OFF_FLAGS_OFS, exp_off);
		set_chan(8'h00, 1'b0);
		rd_chk(SSF_CHANNEL_OFF_FLAGS_OFS, exp_off);
		ssf_host_model_i.wr_reg(8'h33, 8'hff);
		rd_chk(8'h33, 8'h00);
		// With the clock enable low every flag is frozen, so faults are not caught.
		clk_en_in <= 1'b0;
		fault_in <= 4'b1111;
		repeat (2) @(posedge sys_clk_in);
		fault_in <= '0;
		clk_en_in <= 1'b1;
		rd_chk(SSF_VENDOR_FAULT_FLAGS_OFS, 8'h00);
		close_out();
	end
endmodule // ssf_status_regs_tb
bind ssf_status_regs ssf_status_regs_properties #(.CHAN_N(CHAN_N), .CODE_W(CODE_W)) chk_i (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .reg_req_in(reg_req_in),
	.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .fault_in(fault_in),
	.safe_state_in(safe_state_in), .pins_in(pins_in), .selftest_start_in(selftest_start_in),
	.selftest_done_in(selftest_done_in), .selftest_result_in(selftest_result_in),
	.config_load_done_in(config_load_done_in),
	.config_single_corrected_in(config_single_corrected_in),
	.config_double_detected_in(config_double_detected_in), .chan_level_in(chan_level_in),
	.chan_off_thr_in(chan_off_thr_in), .channel_below_off_out(channel_below_off_out),
	.selftest_done_state_out(selftest_done_state_out));
